// ==== src/gcs_pkg.sv ====
// shared constants for the global control and status register bank
package gcs_pkg;
  // register byte addresses (printed offsets are register indices; address = 4 * index)
  localparam int unsigned REG_IDX_BAND0 = 18;
  localparam int unsigned REG_IDX_BAND1 = 19;
  localparam int unsigned REG_IDX_CTRL = 20;
  localparam int unsigned REG_IDX_TIMING = 21;
  localparam int unsigned REG_IDX_XTAL = 22;
  localparam int unsigned REG_IDX_STATUS = 23;
  localparam logic [7:0] ADDR_BAND0 = 8'(REG_IDX_BAND0 * 4);
  localparam logic [7:0] ADDR_BAND1 = 8'(REG_IDX_BAND1 * 4);
  localparam logic [7:0] ADDR_CTRL = 8'(REG_IDX_CTRL * 4);
  localparam logic [7:0] ADDR_TIMING = 8'(REG_IDX_TIMING * 4);
  localparam logic [7:0] ADDR_XTAL = 8'(REG_IDX_XTAL * 4);
  localparam logic [7:0] ADDR_STATUS = 8'(REG_IDX_STATUS * 4);
  localparam logic [7:0] ADDR_DECODE = 8'h7c;
  // control register field positions
  localparam int unsigned CTRL_MODE_HI = 7;
  localparam int unsigned CTRL_MODE_LO = 6;
  localparam int unsigned CTRL_SET = 5;
  localparam int unsigned CTRL_SRC = 4;
  localparam int unsigned CTRL_GATE = 2;
  // timing register field positions
  localparam int unsigned TIM_RATE_LO = 2;
  localparam int unsigned TIM_WIN_LO = 0;
  // crystal register field position
  localparam int unsigned XTAL_DBL = 3;
  // status register field positions
  localparam int unsigned ST_FROZEN = 6;
  localparam int unsigned ST_REF = 4;
  localparam int unsigned ST_XTAL = 3;
  localparam int unsigned ST_LOCK = 2;
  // reset values; fixed-pattern bits of the timing and crystal registers read back as shown
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] TIMING_RST = 8'h68;
  localparam logic [7:0] TIMING_FIXED = 8'h60;
  localparam logic [7:0] TIMING_WMASK = 8'h0f;
  localparam logic [7:0] XTAL_RST = 8'ha0;
  localparam logic [7:0] XTAL_FIXED = 8'ha0;
  localparam logic [7:0] XTAL_WMASK = 8'h08;
  localparam logic [7:0] CTRL_WMASK = 8'hf4;
  localparam logic [6:0] BAND_RST = 7'h00;
  // loop mode codes
  localparam logic [1:0] MODE_LOW_BW = 2'h0;
  localparam logic [1:0] MODE_SYNTH = 2'h1;
  typedef enum logic [1:0] {LOOP_LOW_BW, LOOP_SYNTH, LOOP_HIGH_BW} loop_mode_e;
endpackage

// ==== src/sync2.sv ====
// two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  // first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// ==== src/gcs_top.sv ====
// global control and status register bank of a frequency translator, with apb access
`timescale 1ns/1ps
// Summary of operation
// - mode code 00 low-bandwidth, 01 synthesizer, 10 and 11 high-bandwidth.
// - set source bit 0 gives the pin control, 1 gives register control.
// - set choice bit picks set 0 or 1, only with register control.
// - output enabled only when gate bit and enable pin both high.
// - low-bandwidth sampler rate codes give crystal divided by 16, 8, 4, 2.
// - phase window codes give 2, 4, 8, 16 microseconds.
// - crystal doubler bit doubles crystal before phase detector.
// - input fault flag follows bad reference, mirrored on pin.
// - crystal fault flag follows bad crystal, mirrored on pin.
// - frozen tracking flag set and oscillator held when detector input bad.
// - in low-bandwidth, tuning splits into sampler gain, lower pump, pump reduce.
// - upper loop filter forced to 00 in low-bandwidth mode.
// - modulator order bit 0 second order, 1 third order.
// - modulator on bit 0 integer feedback, 1 fractional feedback.
// - upper pump codes 173, 346, 692 microamps; forced 00 in low-bandwidth.
// - pump reduce bit lowers pump current by one third.
// - lower pump codes give 800, 400, 200, 100 microamps; low-bandwidth only.
module gcs_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic set_select_pin,
  input wire logic out_enable_pin,
  input wire logic ref_bad_in,
  input wire logic crystal_fault_flag_in,
  input wire logic locked_in,
  input wire logic detector_bad_in,
  output logic [1:0] loop_mode,
  output logic active_set,
  output logic out_enable,
  output logic [1:0] sampler_rate,
  output logic [1:0] phase_window_width,
  output logic crystal_doubler,
  output logic [1:0] upper_loop_filter,
  output logic modulator_order,
  output logic modulator_on,
  output logic [1:0] upper_pump_current,
  output logic upper_pump_reduce,
  output logic [3:0] sampler_gain,
  output logic [1:0] lower_pump_current,
  output logic lower_loop_on,
  output logic oscillator_hold,
  output logic ref_fault_pin,
  output logic crystal_fault_pin,
  output logic loop_locked_pin,
  output logic frozen_tracking_pin
);
  // pins from outside the clock domain
  logic [5:0] pins_sync;
  sync2 #(.W(6)) pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({set_select_pin, out_enable_pin, ref_bad_in, crystal_fault_flag_in, locked_in, detector_bad_in}),
    .q(pins_sync)
  );
  logic set_pin_s, oe_pin_s, ref_bad_s, crystal_fault_flag_s, locked_s, det_bad_s;
  assign {set_pin_s, oe_pin_s, ref_bad_s, crystal_fault_flag_s, locked_s, det_bad_s} = pins_sync;

  // software registers
  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] timing_reg, timing_next;
  logic [7:0] xtal_reg, xtal_next;
  logic [6:0] band0_reg, band0_next;
  logic [6:0] band1_reg, band1_next;
  logic [31:0] prdata_next;
  logic pslverr_next, pready_next;
  logic access, wr, hit;
  logic [7:0] status_val;

  assign access = psel & penable;
  assign wr = access & pwrite & pstrb[0];
  // flags are live mirrors of the synchronised conditions, so they self-clear
  assign status_val = {1'b0, det_bad_s, 1'b0, ref_bad_s, crystal_fault_flag_s, locked_s, 2'b00};

  // register write and read decode; one-cycle access phase, pready high whenever out of reset
  always_comb begin
    ctrl_next = ctrl_reg;
    timing_next = timing_reg;
    xtal_next = xtal_reg;
    band0_next = band0_reg;
    band1_next = band1_reg;
    prdata_next = prdata;
    pslverr_next = 1'b0;
    pready_next = 1'b1;
    hit = 1'b1;
    unique case (paddr & gcs_pkg::ADDR_DECODE)
      gcs_pkg::ADDR_BAND0: prdata_next = {25'h0, band0_reg};
      gcs_pkg::ADDR_BAND1: prdata_next = {25'h0, band1_reg};
      gcs_pkg::ADDR_CTRL: prdata_next = {24'h0, ctrl_reg};
      gcs_pkg::ADDR_TIMING: prdata_next = {24'h0, timing_reg};
      gcs_pkg::ADDR_XTAL: prdata_next = {24'h0, xtal_reg};
      gcs_pkg::ADDR_STATUS: prdata_next = {24'h0, status_val};
      default: begin
        prdata_next = 32'h0;
        hit = 1'b0;
      end
    endcase
    if (!access || pwrite) begin
      prdata_next = prdata;
    end
    if (access && (!hit || paddr[1:0] != 2'h0)) begin
      pslverr_next = 1'b1;
    end
    // reserved and fixed positions keep their values whatever the host writes
    if (wr && hit && paddr[1:0] == 2'h0) begin
      unique case (paddr & gcs_pkg::ADDR_DECODE)
        gcs_pkg::ADDR_BAND0: band0_next = pwdata[6:0];
        gcs_pkg::ADDR_BAND1: band1_next = pwdata[6:0];
        gcs_pkg::ADDR_CTRL: ctrl_next = pwdata[7:0] & gcs_pkg::CTRL_WMASK;
        gcs_pkg::ADDR_TIMING: timing_next = (pwdata[7:0] & gcs_pkg::TIMING_WMASK) | gcs_pkg::TIMING_FIXED;
        gcs_pkg::ADDR_XTAL: xtal_next = (pwdata[7:0] & gcs_pkg::XTAL_WMASK) | gcs_pkg::XTAL_FIXED;
        default: ; // status writes ignored
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= gcs_pkg::CTRL_RST;
      timing_reg <= gcs_pkg::TIMING_RST;
      xtal_reg <= gcs_pkg::XTAL_RST;
      band0_reg <= gcs_pkg::BAND_RST;
      band1_reg <= gcs_pkg::BAND_RST;
      prdata <= 32'h0;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      timing_reg <= timing_next;
      xtal_reg <= xtal_next;
      band0_reg <= band0_next;
      band1_reg <= band1_next;
      prdata <= prdata_next;
      pslverr <= pslverr_next;
      pready <= pready_next;
    end
  end

  // decoded operating settings, registered onto the outputs
  gcs_pkg::loop_mode_e mode_e;
  logic set_next;
  logic [6:0] band_sel;
  logic [1:0] mode_next, lf_next, upc_next, lpc_next;
  logic ord_next, mod_next, red_next, oe_next, low_next;
  logic [3:0] gain_next;
  always_comb begin
    unique case (ctrl_reg[gcs_pkg::CTRL_MODE_HI:gcs_pkg::CTRL_MODE_LO])
      gcs_pkg::MODE_LOW_BW: mode_e = gcs_pkg::LOOP_LOW_BW;
      gcs_pkg::MODE_SYNTH: mode_e = gcs_pkg::LOOP_SYNTH;
      default: mode_e = gcs_pkg::LOOP_HIGH_BW; // both upper codes
    endcase
    mode_next = 2'(mode_e);
    // register choice only counts under register control
    set_next = ctrl_reg[gcs_pkg::CTRL_SRC] ? ctrl_reg[gcs_pkg::CTRL_SET] : set_pin_s;
    oe_next = ctrl_reg[gcs_pkg::CTRL_GATE] & oe_pin_s;
    band_sel = set_next ? band1_reg : band0_reg;
    low_next = (mode_e == gcs_pkg::LOOP_LOW_BW);
    red_next = band_sel[0];
    if (low_next) begin
      lf_next = 2'h0;
      ord_next = 1'b0;
      mod_next = 1'b0;
      upc_next = 2'h0;
      gain_next = band_sel[6:3];
      lpc_next = band_sel[2:1];
    end else begin
      lf_next = band_sel[6:5];
      ord_next = band_sel[4];
      mod_next = band_sel[3];
      upc_next = band_sel[2:1];
      gain_next = 4'h0;
      lpc_next = 2'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loop_mode <= 2'h0;
      active_set <= 1'b0;
      out_enable <= 1'b0;
      sampler_rate <= 2'h0;
      phase_window_width <= 2'h0;
      crystal_doubler <= 1'b0;
      upper_loop_filter <= 2'h0;
      modulator_order <= 1'b0;
      modulator_on <= 1'b0;
      upper_pump_current <= 2'h0;
      upper_pump_reduce <= 1'b0;
      sampler_gain <= 4'h0;
      lower_pump_current <= 2'h0;
      lower_loop_on <= 1'b0;
      oscillator_hold <= 1'b0;
      ref_fault_pin <= 1'b0;
      crystal_fault_pin <= 1'b0;
      loop_locked_pin <= 1'b0;
      frozen_tracking_pin <= 1'b0;
    end else begin
      loop_mode <= mode_next;
      active_set <= set_next;
      out_enable <= oe_next;
      sampler_rate <= timing_reg[gcs_pkg::TIM_RATE_LO +: 2];
      phase_window_width <= timing_reg[gcs_pkg::TIM_WIN_LO +: 2];
      crystal_doubler <= xtal_reg[gcs_pkg::XTAL_DBL];
      upper_loop_filter <= lf_next;
      modulator_order <= ord_next;
      modulator_on <= mod_next;
      upper_pump_current <= upc_next;
      upper_pump_reduce <= red_next;
      sampler_gain <= gain_next;
      lower_pump_current <= lpc_next;
      lower_loop_on <= low_next;
      oscillator_hold <= det_bad_s;
      ref_fault_pin <= status_val[gcs_pkg::ST_REF];
      crystal_fault_pin <= status_val[gcs_pkg::ST_XTAL];
      loop_locked_pin <= status_val[gcs_pkg::ST_LOCK];
      frozen_tracking_pin <= status_val[gcs_pkg::ST_FROZEN];
    end
  end

  // checks
  gate_and_a: assert property (@(posedge pclk) disable iff (!presetn)
    out_enable == $past(ctrl_reg[gcs_pkg::CTRL_GATE] & oe_pin_s))
    else $error("output enable not gate and pin");
  set_src_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_reg[gcs_pkg::CTRL_SRC] |=> active_set == $past(set_pin_s))
    else $error("set choice used under pin control");
  high_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[7] |=> loop_mode == 2'(gcs_pkg::LOOP_HIGH_BW))
    else $error("upper mode codes not high bandwidth");
  low_force_a: assert property (@(posedge pclk) disable iff (!presetn)
    lower_loop_on |-> upper_loop_filter == 2'h0 && upper_pump_current == 2'h0)
    else $error("upper loop not forced in low bandwidth");
  lock_mirror_a: assert property (@(posedge pclk) disable iff (!presetn)
    locked_in ##1 locked_in [*3] |=> loop_locked_pin)
    else $error("lock pin lags input");
  xtal_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    !crystal_fault_flag_in [*4] |=> !crystal_fault_pin)
    else $error("crystal flag did not self clear");
  ref_mirror_a: assert property (@(posedge pclk) disable iff (!presetn)
    ref_bad_in [*4] |=> ref_fault_pin)
    else $error("input fault flag not set");
  frozen_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    detector_bad_in [*4] |=> oscillator_hold && frozen_tracking_pin)
    else $error("hold and flag not raised by bad detector input");
  status_ro_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == gcs_pkg::ADDR_STATUS |=> $stable(ctrl_reg) && $stable(timing_reg)
      && $stable(xtal_reg) && $stable(band0_reg) && $stable(band1_reg))
    else $error("status write changed state");
  gain_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    !lower_loop_on |-> sampler_gain == 4'h0 && lower_pump_current == 2'h0)
    else $error("low bandwidth fields leak");
  // mode decode and set choice under register control
  synth_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[gcs_pkg::CTRL_MODE_HI:gcs_pkg::CTRL_MODE_LO] == gcs_pkg::MODE_SYNTH
      |=> loop_mode == 2'(gcs_pkg::LOOP_SYNTH))
    else $error("synthesizer code not decoded");
  low_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) && ctrl_reg[gcs_pkg::CTRL_MODE_HI:gcs_pkg::CTRL_MODE_LO] == gcs_pkg::MODE_LOW_BW
      |=> loop_mode == 2'(gcs_pkg::LOOP_LOW_BW) && lower_loop_on)
    else $error("low bandwidth code not decoded");
  reg_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_reg[gcs_pkg::CTRL_SRC] |=> active_set == $past(ctrl_reg[gcs_pkg::CTRL_SET]))
    else $error("register set choice not applied");
  // field copies lag one edge; the guard skips the edge that still shows reset values
  rate_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) |-> sampler_rate == $past(timing_reg[gcs_pkg::TIM_RATE_LO +: 2]))
    else $error("sampler rate not copied");
  window_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) |-> phase_window_width == $past(timing_reg[gcs_pkg::TIM_WIN_LO +: 2]))
    else $error("phase window not copied");
  doubler_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) |-> crystal_doubler == $past(xtal_reg[gcs_pkg::XTAL_DBL]))
    else $error("crystal doubler not copied");
  upper_split_a: assert property (@(posedge pclk) disable iff (!presetn)
    !low_next |=> upper_loop_filter == $past(band_sel[6:5]) && modulator_order == $past(band_sel[4])
      && modulator_on == $past(band_sel[3]) && upper_pump_current == $past(band_sel[2:1]))
    else $error("upper loop fields not split from tuning");
  lower_split_a: assert property (@(posedge pclk) disable iff (!presetn)
    low_next |=> sampler_gain == $past(band_sel[6:3])
      && lower_pump_current == $past(band_sel[2:1]))
    else $error("lower loop fields not split from tuning");
  reduce_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) |-> upper_pump_reduce == $past(band_sel[0]))
    else $error("pump reduce bit not applied");
  mod_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    lower_loop_on |-> !modulator_order && !modulator_on)
    else $error("modulator active in low bandwidth");
endmodule

// ==== verif/apb_host.sv ====
// behavioural apb host model issuing one transfer per start pulse
`timescale 1ns/1ps
module apb_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic wr,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  output logic done,
  output logic [31:0] rdata,
  output logic err
);
  int ph;
  // request held until pready; slave registers its answer, so data is taken one edge later
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph <= 0;
      psel <= 1'h0;
      penable <= 1'h0;
      pwrite <= 1'h0;
      paddr <= 8'h00;
      pwdata <= 32'h0;
      pstrb <= 4'h0;
      done <= 1'h0;
      rdata <= 32'h0;
      err <= 1'h0;
    end else begin
      done <= 1'h0;
      case (ph)
        0: if (start) begin
          psel <= 1'h1;
          pwrite <= wr;
          paddr <= addr;
          pwdata <= wdata;
          pstrb <= 4'hf;
          ph <= 1;
        end
        1: begin
          penable <= 1'h1;
          ph <= 2;
        end
        2: if (pready) begin
          psel <= 1'h0;
          penable <= 1'h0;
          paddr <= ~paddr; // released lines must not keep the old value
          pwdata <= ~pwdata;
          ph <= 3;
        end
        default: begin
          rdata <= prdata;
          err <= pslverr;
          done <= 1'h1;
          ph <= 0;
        end
      endcase
    end
  end
endmodule

// ==== verif/clock_translator_global_ctrl_status_tb.sv ====
// self-checking bench for the global control and status bank
`timescale 1ns/1ps
module clock_translator_global_ctrl_status_tb;
  logic pclk, presetn, start, wr, psel, penable, pwrite, pready, pslverr, done, err;
  logic [7:0] addr, paddr;
  logic [31:0] wdata, pwdata, prdata, rdata, rs;
  logic [3:0] pstrb, sampler_gain;
  logic [5:0] pins;
  logic [1:0] loop_mode, sampler_rate, phase_window_width, upper_loop_filter, upper_pump_current, lower_pump_current;
  logic active_set, out_enable, crystal_doubler, modulator_order, modulator_on, upper_pump_reduce, lower_loop_on;
  logic oscillator_hold, ref_fault_pin, crystal_fault_pin, loop_locked_pin, frozen_tracking_pin;
  int err_count, n_checks;
  logic [7:0] adr[5];
  logic [31:0] wv[5], msk[5], fix[5], rst[5], st;
  initial begin
    pclk = 0;
    forever #4 pclk = ~pclk;
  end
  apb_host i_apb_host (.pclk, .presetn, .start, .wr, .addr, .wdata, .pready, .prdata, .pslverr, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .done, .rdata, .err);
  gcs_top i_gcs_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .set_select_pin(pins[0]), .out_enable_pin(pins[1]), .ref_bad_in(pins[2]), .crystal_fault_flag_in(pins[3]),
    .locked_in(pins[4]), .detector_bad_in(pins[5]), .loop_mode, .active_set, .out_enable, .sampler_rate,
    .phase_window_width, .crystal_doubler, .upper_loop_filter, .modulator_order, .modulator_on, .upper_pump_current,
    .upper_pump_reduce, .sampler_gain, .lower_pump_current, .lower_loop_on, .oscillator_hold, .ref_fault_pin,
    .crystal_fault_pin, .loop_locked_pin, .frozen_tracking_pin);
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one transfer through the host model; a hang counts as a mismatch
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    start <= 1'h1;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge pclk);
    start <= 1'h0;
    for (k = 0; k < 20 && !done; k++) @(posedge pclk) #1;
    if (!done) begin
      err_count++;
      print_verdict();
    end
  endtask
  // expected port values from the written words and pin levels
  task automatic chk_outs();
    logic [6:0] b;
    logic [1:0] m;
    m = wv[2][7:6];
    b = (wv[2][4] ? wv[2][5] : pins[0]) ? wv[1][6:0] : wv[0][6:0];
    chk("mode", loop_mode, m == 2'h0 ? 0 : m == 2'h1 ? 1 : 2);
    chk("set", active_set, wv[2][4] ? wv[2][5] : pins[0]);
    chk("oe", out_enable, wv[2][2] & pins[1]);
    chk("timing", {sampler_rate, phase_window_width, crystal_doubler}, {wv[3][3:0], wv[4][3]});
    if (m == 2'h0) chk("lowbw", {upper_loop_filter, modulator_order, modulator_on, upper_pump_current, upper_pump_reduce,
      sampler_gain, lower_pump_current, lower_loop_on}, {6'h0, b[0], b[6:3], b[2:1], 1'h1});
    else chk("upbw", {upper_loop_filter, modulator_order, modulator_on, upper_pump_current, upper_pump_reduce,
      sampler_gain, lower_pump_current, lower_loop_on}, {b, 7'h0});
    chk("pins", {oscillator_hold, ref_fault_pin, crystal_fault_pin, loop_locked_pin, frozen_tracking_pin},
      {pins[5], pins[2], pins[3], pins[4], pins[5]});
  endtask
  initial begin
    rs = 32'he9679a06;
    presetn = 1'h0;
    start = 1'h0;
    wr = 1'h0;
    addr = 8'h00;
    wdata = 32'h0;
    pins = 6'h00;
    adr = '{gcs_pkg::ADDR_BAND0, gcs_pkg::ADDR_BAND1, gcs_pkg::ADDR_CTRL, gcs_pkg::ADDR_TIMING, gcs_pkg::ADDR_XTAL};
    msk = '{32'h7f, 32'h7f, 32'hf4, 32'h0f, 32'h08};
    fix = '{32'h0, 32'h0, 32'h0, 32'h60, 32'ha0};
    rst = '{32'h0, 32'h0, 32'h00, 32'h68, 32'ha0};
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    for (int j = 0; j < 5; j++) begin
      acc(1'h0, adr[j], 32'h0);
      chk("reset value", rdata, rst[j]);
    end
    $display("test reset values done");
    // modes walk all four codes; other fields random with reserved bits zero
    for (int i = 0; i < 16; i++) begin
      for (int j = 0; j < 5; j++) wv[j] = rnd() & msk[j];
      wv[2][7:6] = 2'(i);
      @(posedge pclk);
      pins <= 6'(rnd());
      for (int j = 0; j < 5; j++) acc(1'h1, adr[j], wv[j]);
      repeat (5) @(posedge pclk);
      #1 chk_outs();
      for (int j = 0; j < 5; j++) begin
        acc(1'h0, adr[j], 32'h0);
        chk("readback", rdata, wv[j] | fix[j]);
        chk("slverr", err, 1'h0);
      end
      st = {25'h0, pins[5], 1'h0, pins[2], pins[3], pins[4], 2'h0};
      acc(1'h1, gcs_pkg::ADDR_STATUS, 32'h5c);
      acc(1'h0, gcs_pkg::ADDR_STATUS, 32'h0);
      chk("status", rdata, st);
      acc(1'h0, gcs_pkg::ADDR_DECODE, 32'h0);
      chk("unmapped", err, 1'h1);
      acc(1'h1, 8'h51, 32'h0);
      chk("misaligned", err, 1'h1);
      acc(1'h0, gcs_pkg::ADDR_CTRL, 32'h0);
      chk("ctrl kept", rdata, wv[2]);
    end
    $display("test random settings done");
    // 4 MHz high-bandwidth setting: pump 10, reduce 0, filter 11 on set 0 under register control
    acc(1'h1, gcs_pkg::ADDR_BAND0, 32'h64);
    acc(1'h1, gcs_pkg::ADDR_CTRL, 32'h90);
    repeat (3) @(posedge pclk);
    #1 chk("four mhz", {loop_mode, upper_loop_filter, upper_pump_current, upper_pump_reduce},
      {2'h2, 2'h3, 2'h2, 1'h0});
    $display("test four mhz setting done");
    // second reset in mid-run: outputs clear at once, registers return to reset values
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    #1 chk("reset outputs", {loop_mode, active_set, out_enable, upper_loop_filter, pready}, 7'h0);
    @(posedge pclk);
    presetn <= 1'h1;
    acc(1'h0, gcs_pkg::ADDR_TIMING, 32'h0);
    chk("timing after reset", rdata, rst[3]);
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule
